// ---- design/sfs_supervisor.sv ----
// Design decisions made here: the placing of the registers and the APB register port.
`timescale 1ns/1ps
// What this block does
// - supply low warning: report only, pin and status
// - driver lockout: shutdown, pin, fault bit
// - lockout disable stops shutdown, bit still set
// - supply over warning: report only, pin, status
// - pump overvoltages latch as faults
// - pump undervoltage: shutdown, pin, fault bit
// - low-side undervoltage: shutdown, pin, fault bit
// - pump and low-side protection never disabled
// - four temperature levels real-time, no pin
// - overtemp warning real-time, drives pin
// - overtemp fault latches shutdown, registers kept
// - overtemp clears only when cool and cleared
// - watchdog off after reset, software enables
// - watchdog interval selectable, status read restarts
// - watchdog fault latches, power-good pulses low
// - watchdog fault: pin, enable cleared, bit
// - regulator threshold select and monitor disable
// - regulator undervoltage latches, holds power-good low
// - self-clearing clear bit clears gone faults
// - gate-enable high-low-high pulse clears faults
// - power-up holds pin low until lockout passes
// - fault while operating returns to standby
module sfs_supervisor #(
  parameter int unsigned WD_MS_CYCLES = sfs_pkg::SFS_WD_MS_CYC
) (
  // clock and reset
  input  wire logic                        sys_clk,
  input  wire logic                        rstn,
  // apb slave
  input  wire logic [sfs_pkg::SFS_AW-1:0]  paddr,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  // comparator results
  input  wire logic                        supply_low_warning,
  input  wire logic                        driver_supply_lockout,
  input  wire logic                        supply_over_warning,
  input  wire logic                        pump_relative_over_fault,
  input  wire logic                        pump_absolute_over_fault,
  input  wire logic                        pump_under_fault,
  input  wire logic                        low_side_supply_under_fault,
  input  wire logic                        regulator_under_fault,
  // temperature comparators
  input  wire logic                        temp_level_one,
  input  wire logic                        temp_level_two,
  input  wire logic                        temp_level_three,
  input  wire logic                        temp_level_four,
  input  wire logic                        overtemp_warning,
  input  wire logic                        overtemp_shutdown,
  // controller pin
  input  wire logic                        gate_enable,
  // pins and analog controls
  output logic                             fault_out_n,
  output logic                             power_good_out,
  output logic                             gate_drive_enable,
  output logic                             pulldown_enable,
  output logic                             regulator_enable,
  output logic      [1:0]                  regulator_under_threshold
);
  import sfs_pkg::*;

  typedef enum logic [1:0] {SFS_POWERUP, SFS_STANDBY, SFS_OPERATE} sfs_state_t;

  sfs_wd_if wd_link ();

  logic                  rst_q1;
  logic                  rst_n;
  logic                  apb_acc;
  logic                  wr_done;
  logic                  rd_done;
  logic [3:0]            idx;
  logic                  mapped;
  logic [SFS_DW-1:0]     warn;
  logic [SFS_DW-1:0]     faults;
  logic [SFS_DW-1:0]     fault_set;
  logic [SFS_DW-1:0]     fault_cond;
  logic [SFS_DW-1:0]     fault_keep;
  logic [SFS_DW-1:0]     next_faults;
  logic [SFS_DW-1:0]     act_mask;
  logic [SFS_DW-1:0]     rd_mux;
  logic                  clear_pending;
  logic                  lock_disable;
  logic                  wd_enable;
  logic [1:0]            wd_interval;
  logic                  mon_disable;
  logic [1:0]            reg_thresh;
  logic                  gate_q;
  logic                  gate_seen_high;
  logic [5:0]            gate_low_cnt;
  logic                  gate_pulse;
  logic                  clear_now;
  logic                  shutdown;
  logic                  warn_pin;
  sfs_state_t            state;
  sfs_state_t            next_state;

  // reset release through two flops
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rst_q1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n  <= rst_q1;
    end
  end

  // apb decode, one wait state per access
  assign apb_acc = psel && penable;
  assign wr_done = apb_acc && pready && pwrite;
  assign rd_done = apb_acc && pready && !pwrite;
  assign idx     = paddr[5:2];
  assign mapped  = paddr[1:0] == 2'h0 && paddr[7:6] == 2'h0
                   && (idx == SFS_IDX_WARN || idx == SFS_IDX_FAULT
                   || idx == SFS_IDX_CTRL || idx == SFS_IDX_REG);

  // real-time warning status
  always_comb begin
    warn = '0;
    warn[SFS_W_TEMP4] = temp_level_four;
    warn[SFS_W_LOW]   = supply_low_warning;
    warn[SFS_W_OVER]  = supply_over_warning;
    warn[SFS_W_TEMP1] = temp_level_one;
    warn[SFS_W_TEMP2] = temp_level_two;
    warn[SFS_W_TEMP3] = temp_level_three;
    warn[SFS_W_OTW]   = overtemp_warning;
  end

  // read data selection
  always_comb begin
    rd_mux = '0;
    if (idx == SFS_IDX_WARN) begin
      rd_mux = warn;
    end else if (idx == SFS_IDX_FAULT) begin
      rd_mux = faults;
    end else if (idx == SFS_IDX_CTRL) begin
      rd_mux[SFS_C_LOCKDIS] = lock_disable;
      rd_mux[SFS_C_WDI_LO +: 2] = wd_interval;
      rd_mux[SFS_C_WDEN] = wd_enable;
      rd_mux[SFS_C_CLR] = clear_pending;
    end else if (idx == SFS_IDX_REG) begin
      rd_mux[SFS_R_MONDIS] = mon_disable;
      rd_mux[SFS_R_THR_LO +: 2] = reg_thresh;
    end
  end

  // ready, read data and error answer
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready  <= apb_acc && !pready;
      pslverr <= apb_acc && !pready && !mapped;
      if (apb_acc && !pready) begin
        prdata <= (mapped && !pwrite) ? {21'h0, rd_mux} : 32'h0;
      end
    end
  end

  // control register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_disable <= SFS_CTRL_RST[SFS_C_LOCKDIS];
      wd_interval  <= SFS_CTRL_RST[SFS_C_WDI_LO +: 2];
    end else if (wr_done && mapped && idx == SFS_IDX_CTRL) begin
      lock_disable <= pwdata[SFS_C_LOCKDIS];
      wd_interval  <= pwdata[SFS_C_WDI_LO +: 2];
    end
  end

  // watchdog enable, dropped by expiry
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wd_enable <= SFS_CTRL_RST[SFS_C_WDEN];
    end else if (wd_link.wd_expire) begin
      wd_enable <= 1'b0;
    end else if (wr_done && mapped && idx == SFS_IDX_CTRL) begin
      wd_enable <= pwdata[SFS_C_WDEN];
    end
  end

  // self-clearing clear request
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      clear_pending <= SFS_CTRL_RST[SFS_C_CLR];
    end else if (wr_done && mapped && idx == SFS_IDX_CTRL) begin
      clear_pending <= pwdata[SFS_C_CLR];
    end else if (clear_pending && faults == '0) begin
      clear_pending <= 1'b0;
    end
  end

  // regulator monitor register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mon_disable <= SFS_REG_RST[SFS_R_MONDIS];
      reg_thresh  <= SFS_REG_RST[SFS_R_THR_LO +: 2];
    end else if (wr_done && mapped && idx == SFS_IDX_REG) begin
      mon_disable <= pwdata[SFS_R_MONDIS];
      reg_thresh  <= pwdata[SFS_R_THR_LO +: 2];
    end
  end

  // watchdog timer link
  assign wd_link.wd_enable   = wd_enable;
  assign wd_link.wd_interval = wd_interval;
  assign wd_link.wd_kick     = rd_done && mapped && idx == SFS_IDX_WARN;
  assign wd_link.reg_under   = regulator_under_fault && !mon_disable;

  sfs_watchdog #(
    .MS_CYCLES (WD_MS_CYCLES)
  ) u_watchdog (
    .clk   (sys_clk),
    .rst_n (rst_n),
    .wd    (wd_link.wdog)
  );

  // gate-enable reset pulse detector
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      gate_q         <= 1'b0;
      gate_seen_high <= 1'b0;
      gate_low_cnt   <= 6'h0;
      gate_pulse     <= 1'b0;
    end else begin
      gate_q <= gate_enable;
      if (gate_enable && !gate_q) begin
        gate_seen_high <= 1'b1;
      end
      if (gate_enable) begin
        gate_low_cnt <= 6'h0;
      end else if (gate_low_cnt != 6'(SFS_GATE_LOW_CYC)) begin
        gate_low_cnt <= gate_low_cnt + 6'h1;
      end
      gate_pulse <= gate_enable && !gate_q && gate_seen_high
                    && gate_low_cnt == 6'(SFS_GATE_LOW_CYC);
    end
  end

  assign clear_now = clear_pending || gate_pulse;

  // fault events and still-present conditions
  always_comb begin
    fault_set  = '0;
    fault_cond = '0;
    fault_set[SFS_F_LOCK]    = driver_supply_lockout;
    fault_set[SFS_F_WDOG]    = wd_link.wd_expire;
    fault_set[SFS_F_OVERTEMP_SHUTDOWN]    = overtemp_shutdown;
    fault_set[SFS_F_REGUV]   = wd_link.reg_under;
    fault_set[SFS_F_LSUV]    = low_side_supply_under_fault;
    fault_set[SFS_F_PUMPUV]  = pump_under_fault;
    fault_set[SFS_F_PUMPABS] = pump_absolute_over_fault;
    fault_set[SFS_F_PUMPREL] = pump_relative_over_fault;
    fault_cond = fault_set;
    fault_cond[SFS_F_WDOG] = 1'b0;
  end

  // clear keeps only faults whose cause remains
  assign fault_keep  = clear_now ? fault_cond : '1;
  assign next_faults = fault_set | (faults & fault_keep);

  // latched fault status, set beats clear
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      faults <= '0;
    end else if (state != SFS_POWERUP) begin
      faults <= next_faults;
    end
  end

  // faults that act on pin and driver
  always_comb begin
    act_mask = '1;
    act_mask[SFS_F_LOCK] = !lock_disable;
  end

  assign shutdown = |(faults & act_mask) || |(fault_set & act_mask);
  assign warn_pin = supply_low_warning || supply_over_warning
                    || overtemp_warning;

  // operating state sequencing
  always_comb begin
    next_state = state;
    unique case (state)
      SFS_POWERUP: begin
        if (!driver_supply_lockout) begin
          next_state = SFS_STANDBY;
        end
      end
      SFS_STANDBY: begin
        if (gate_enable && !gate_q && !shutdown) begin
          next_state = SFS_OPERATE;
        end
      end
      SFS_OPERATE: begin
        if (!gate_enable || shutdown) begin
          next_state = SFS_STANDBY;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= SFS_POWERUP;
    end else begin
      state <= next_state;
    end
  end

  // driver and regulator controls
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      gate_drive_enable <= 1'b0;
      pulldown_enable   <= 1'b1;
      regulator_enable  <= 1'b0;
      regulator_under_threshold <= 2'h0;
    end else begin
      gate_drive_enable <= next_state == SFS_OPERATE;
      pulldown_enable   <= next_state != SFS_OPERATE;
      regulator_enable  <= 1'b1;
      regulator_under_threshold <= reg_thresh;
    end
  end

  // fault and power-good pins
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_out_n    <= 1'b0;
      power_good_out <= 1'b0;
    end else begin
      fault_out_n <= !(next_state == SFS_POWERUP
                       || |(next_faults & act_mask)
                       || warn_pin);
      power_good_out <= !wd_link.pg_low;
    end
  end

endmodule

// ---- design/sfs_watchdog.sv ----
`timescale 1ns/1ps
module sfs_watchdog #(
  parameter int unsigned MS_CYCLES = 50000
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // link to supervisor
  sfs_wd_if.wdog   wd
);
  import sfs_pkg::*;

  logic [31:0] ms_count;
  logic        ms_tick;
  logic [6:0]  remain;
  logic [11:0] pg_count;
  logic        armed;

  assign ms_tick = (ms_count == MS_CYCLES - 1);

  // millisecond enable, restarted by a kick
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ms_count <= 32'h0;
    end else if (!wd.wd_enable || wd.wd_kick || ms_tick) begin
      ms_count <= 32'h0;
    end else begin
      ms_count <= ms_count + 32'h1;
    end
  end

  // countdown of whole milliseconds
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      remain <= 7'h0;
    end else if (!armed || wd.wd_kick) begin
      remain <= sfs_wd_ms(wd.wd_interval);
    end else if (ms_tick && remain != 7'h0) begin
      remain <= remain - 7'h1;
    end
  end

  // expiry pulse; armed lags enable so a reload sees the new interval
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wd.wd_expire <= 1'b0;
      armed <= 1'b0;
    end else begin
      armed <= wd.wd_enable;
      wd.wd_expire <= wd.wd_enable && !wd.wd_kick && ms_tick
                      && remain == 7'h1;
    end
  end

  // power-good low stretch
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pg_count <= 12'h0;
    end else if (wd.wd_expire || wd.reg_under) begin
      pg_count <= 12'(SFS_PG_LOW_CYC);
    end else if (pg_count != 12'h0) begin
      pg_count <= pg_count - 12'h1;
    end
  end

  // low while stretching or regulator low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wd.pg_low <= 1'b0;
    end else begin
      wd.pg_low <= wd.reg_under || pg_count != 12'h0;
    end
  end
endmodule

// ---- dv/sfs_mcu_model.sv ----
`timescale 1ns/1ps
module sfs_mcu_model
  import sfs_pkg::*;
(
  // clock
  input wire logic                       sys_clk,
  // apb master
  output logic [sfs_pkg::SFS_AW-1:0]     paddr,
  output logic                           psel,
  output logic                           penable,
  output logic                           pwrite,
  output logic [31:0]                    pwdata,
  input wire logic [31:0]                prdata,
  input wire logic                       pready,
  input wire logic                       pslverr,
  // gate enable pin
  output logic                           gate_enable
);
  // bus idle and gate low at time zero
  initial begin
    paddr       = 8'h00;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    pwdata      = 32'h0;
    gate_enable = 1'b0;
  end

  // one apb transfer
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    paddr   <= ~a; // no stale value
    pwdata  <= ~d;
    @(posedge sys_clk);
  endtask

  // gate level and high-low-high clearing pulse
  task automatic gate(input logic v);
    gate_enable <= v;
  endtask
  task automatic gate_pulse();
    gate_enable <= 1'b0;
    repeat (SFS_GATE_LOW_CYC) @(posedge sys_clk);
    gate_enable <= 1'b1;
  endtask
endmodule

// ---- dv/sfs_supervisor_monitor.sv ----
`timescale 1ns/1ps
module sfs_supervisor_monitor
  import sfs_pkg::*;
(
  // clock and reset
  input wire logic                       sys_clk,
  input wire logic                       rstn,
  // apb slave side
  input wire logic [sfs_pkg::SFS_AW-1:0] paddr,
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pready,
  input wire logic                       pslverr,
  // conditions
  input wire logic                       supply_low_warning,
  input wire logic                       supply_over_warning,
  input wire logic                       overtemp_warning,
  input wire logic                       pump_relative_over_fault,
  input wire logic                       pump_under_fault,
  input wire logic                       low_side_supply_under_fault,
  // pins
  input wire logic                       fault_out_n,
  input wire logic                       power_good_out,
  input wire logic                       gate_drive_enable,
  input wire logic                       pulldown_enable
);
  logic        seen_high;
  logic [15:0] low_cnt;

  // power-good low time, ignoring the low before the first rise
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      seen_high <= 1'b0;
      low_cnt   <= 16'h0000;
    end else begin
      seen_high <= seen_high | power_good_out;
      low_cnt   <= (power_good_out || !seen_high) ? 16'h0000 : low_cnt + 16'h0001;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  // building blocks
  sequence s_held3(x);
    x [*3];
  endsequence
  sequence s_waiting;
    psel && penable && !pready;
  endsequence

  a_low_warn_pin: assert property (s_held3(supply_low_warning) |-> !fault_out_n)
    else $error("supply low warning left fault pin high");
  a_over_warn_pin: assert property (s_held3(supply_over_warning) |-> !fault_out_n)
    else $error("supply over warning left fault pin high");
  a_otw_pin: assert property (s_held3(overtemp_warning) |-> !fault_out_n)
    else $error("overtemp warning left fault pin high");
  a_pump_over_pin: assert property (pump_relative_over_fault |-> ##[1:3] !fault_out_n)
    else $error("pump overvoltage did not pull fault pin low");
  a_pump_uv_stop: assert property (pump_under_fault
    |-> ##[1:4] !gate_drive_enable)
    else $error("pump undervoltage left gate drive on");
  a_ls_uv_stop: assert property (low_side_supply_under_fault
    |-> ##[1:4] !gate_drive_enable)
    else $error("low-side undervoltage left gate drive on");
  a_pg_low_min: assert property ($rose(power_good_out) && seen_high
    |-> low_cnt >= 16'(SFS_PG_LOW_CYC))
    else $error("power good low pulse too short");
  a_drive_pulldown: assert property (gate_drive_enable |-> !pulldown_enable)
    else $error("gate drive and pulldown on together");
  a_apb_wait_one: assert property (s_waiting |=> pready)
    else $error("access phase not answered after one wait");
  a_apb_ready_once: assert property (pready |=> !pready)
    else $error("ready held for more than one cycle");
  a_apb_unmapped: assert property (pready && paddr[5:2] == 4'h0 |-> pslverr)
    else $error("unmapped access without error");
endmodule

bind sfs_supervisor sfs_supervisor_monitor u_mon (
  .sys_clk(sys_clk), .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .supply_low_warning(supply_low_warning),
  .supply_over_warning(supply_over_warning), .overtemp_warning(overtemp_warning),
  .pump_relative_over_fault(pump_relative_over_fault), .pump_under_fault(pump_under_fault),
  .low_side_supply_under_fault(low_side_supply_under_fault), .fault_out_n(fault_out_n),
  .power_good_out(power_good_out), .gate_drive_enable(gate_drive_enable),
  .pulldown_enable(pulldown_enable)
);

// ---- dv/tb_supply_fault_supervisor.sv ----
`timescale 1ns/1ps
module tb_supply_fault_supervisor;
  import sfs_pkg::*;
  localparam int WD = 20;
  localparam logic [7:0] A_WARN = {2'b00, SFS_IDX_WARN, 2'b00};
  localparam logic [7:0] A_FLT = {2'b00, SFS_IDX_FAULT, 2'b00};
  localparam logic [7:0] A_CTRL = {2'b00, SFS_IDX_CTRL, 2'b00};
  localparam logic [7:0] A_REG = {2'b00, SFS_IDX_REG, 2'b00};
  localparam int WBIT[7] = '{8, 7, 6, 3, 2, 1, 0};
  localparam logic [6:0] WPIN = 7'h46;
  localparam int FBIT[7] = '{10, 8, 6, 4, 2, 1, 0};
  localparam int WMS[4] = '{int'(SFS_WD_MS0), int'(SFS_WD_MS1), int'(SFS_WD_MS2),
                            int'(SFS_WD_MS3)};
  logic        sys_clk = 1'b0;
  logic        rstn;
  logic [6:0]  warn;
  logic [6:0]  flt;
  logic [7:0]  paddr;
  logic        psel, penable, pwrite, pready, pslverr, gate_enable;
  logic [31:0] pwdata, prdata;
  logic        fault_out_n, power_good_out, gate_drive_enable, pulldown_enable;
  logic        regulator_enable;
  logic [1:0]  regulator_under_threshold;
  int          n_errors = 0;
  int          checks = 0;

  // 50 MHz clock
  always #10 sys_clk = ~sys_clk;

  sfs_supervisor #(.WD_MS_CYCLES(WD)) DUT (
    .sys_clk(sys_clk), .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .temp_level_four(warn[0]), .supply_low_warning(warn[1]), .supply_over_warning(warn[2]),
    .temp_level_one(warn[3]), .temp_level_two(warn[4]), .temp_level_three(warn[5]),
    .overtemp_warning(warn[6]), .driver_supply_lockout(flt[0]), .overtemp_shutdown(flt[1]),
    .regulator_under_fault(flt[2]), .low_side_supply_under_fault(flt[3]),
    .pump_under_fault(flt[4]), .pump_absolute_over_fault(flt[5]),
    .pump_relative_over_fault(flt[6]), .gate_enable(gate_enable), .fault_out_n(fault_out_n),
    .power_good_out(power_good_out), .gate_drive_enable(gate_drive_enable),
    .pulldown_enable(pulldown_enable), .regulator_enable(regulator_enable),
    .regulator_under_threshold(regulator_under_threshold));

  sfs_mcu_model u_mcu (
    .sys_clk(sys_clk), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .gate_enable(gate_enable));

  // compare, bus and wait helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic        e;
    u_mcu.xfer(1'b0, a, 32'h0, q, e);
    chk(q, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    u_mcu.xfer(1'b1, a, d, q, e);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic op_on();
    u_mcu.gate(1'b0);
    cyc(2);
    u_mcu.gate(1'b1);
    cyc(3);
  endtask

  // power-up pin, reset values, bus errors
  task automatic t_power_up();
    logic [31:0] q;
    logic        e;
    cyc(10);
    chk(32'(fault_out_n), 32'h0);
    chk(32'(regulator_enable), 32'h1);
    chk(32'(pulldown_enable), 32'h1);
    rdc(A_CTRL, 32'(SFS_CTRL_RST));
    rdc(A_REG, 32'(SFS_REG_RST));
    flt <= 7'h00;
    cyc(4);
    chk(32'(fault_out_n), 32'h1);
    rdc(A_FLT, 32'h0);
    u_mcu.xfer(1'b0, 8'h00, 32'h0, q, e);
    chk(q, 32'h0);
    chk(32'(e), 32'h1);
    wr(A_FLT, 32'h7ff);
    rdc(A_FLT, 32'h0);
  endtask

  // each warning: real-time status bit, pin only for some
  task automatic t_warn();
    for (int i = 0; i < 7; i++) begin
      warn <= 7'h01 << i;
      cyc(4);
      chk(32'(fault_out_n), 32'(!WPIN[i]));
      rdc(A_WARN, 32'h1 << WBIT[i]);
    end
    warn <= 7'h00;
  endtask

  // each latched comparator fault: shutdown, hold, clear
  task automatic t_faults();
    for (int i = 0; i < 7; i++) begin
      op_on();
      chk(32'(gate_drive_enable), 32'h1);
      flt <= 7'h01 << i;
      cyc(5);
      chk(32'(gate_drive_enable), 32'h0);
      chk(32'(fault_out_n), 32'h0);
      if (i == 2) chk(32'(power_good_out), 32'h0);
      wr(A_CTRL, 32'h2);
      rdc(A_FLT, 32'h1 << FBIT[i]);
      flt <= 7'h00;
      cyc(6);
      rdc(A_FLT, 32'h0);
      rdc(A_CTRL, 32'h0);
      chk(32'(fault_out_n), 32'h1);
    end
    cyc(SFS_PG_LOW_CYC);
  endtask

  // lockout disabled: bit set, gate pulse clears
  task automatic t_lockdis();
    wr(A_CTRL, 32'h200);
    op_on();
    flt <= 7'h01;
    cyc(5);
    chk(32'(gate_drive_enable), 32'h1);
    rdc(A_FLT, 32'h400);
    flt <= 7'h00;
    u_mcu.gate_pulse();
    cyc(3);
    rdc(A_FLT, 32'h0);
    wr(A_CTRL, 32'h0);
  endtask

  // regulator threshold and monitor disable
  task automatic t_regmon();
    wr(A_REG, 32'h6);
    cyc(2);
    chk(32'(regulator_under_threshold), 32'h2);
    rdc(A_REG, 32'h6);
    flt <= 7'h04;
    cyc(5);
    chk(32'(power_good_out), 32'h1);
    rdc(A_FLT, 32'h0);
    flt <= 7'h00;
    wr(A_REG, 32'h0);
  endtask

  // watchdog: each interval, restart, expiry
  task automatic t_wdog();
    for (int s = 0; s < 4; s++) begin
      wr(A_CTRL, (32'(s) << 5) | 32'h8);
      cyc(WMS[s] * WD / 2);
      rdc(A_WARN, 32'h0);
      cyc(WMS[s] * WD - 10);
      chk(32'(power_good_out), 32'h1);
      cyc(20);
      chk(32'(power_good_out), 32'h0);
      chk(32'(fault_out_n), 32'h0);
      rdc(A_FLT, 32'h200);
      rdc(A_CTRL, 32'(s) << 5);
      cyc(SFS_PG_LOW_CYC);
      chk(32'(power_good_out), 32'h1);
      wr(A_CTRL, 32'h2);
      cyc(4);
      rdc(A_FLT, 32'h0);
    end
  endtask

  task automatic end_of_test();
    if (n_errors == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    rstn = 1'b0;
    warn = 7'h00;
    flt  = 7'h01;
    cyc(20);
    rstn <= 1'b1;
    t_power_up();
    t_warn();
    t_faults();
    t_lockdis();
    t_regmon();
    t_wdog();
    end_of_test();
  end

  // hang guard
  initial begin
    cyc(40000);
    n_errors++;
    end_of_test();
  end
endmodule

// ---- include/sfs_pkg.sv ----
package sfs_pkg;
  // register data width and apb address width
  localparam int unsigned SFS_DW = 11;
  localparam int unsigned SFS_AW = 8;
  // register indices, byte address is four times the index
  localparam logic [3:0] SFS_IDX_WARN = 4'h1;
  localparam logic [3:0] SFS_IDX_FAULT = 4'h3;
  localparam logic [3:0] SFS_IDX_CTRL = 4'h9;
  localparam logic [3:0] SFS_IDX_REG = 4'hb;
  // warning status fields
  localparam int unsigned SFS_W_TEMP4 = 8;
  localparam int unsigned SFS_W_LOW = 7;
  localparam int unsigned SFS_W_OVER = 6;
  localparam int unsigned SFS_W_TEMP1 = 3;
  localparam int unsigned SFS_W_TEMP2 = 2;
  localparam int unsigned SFS_W_TEMP3 = 1;
  localparam int unsigned SFS_W_OTW = 0;
  // latched fault fields
  localparam int unsigned SFS_F_LOCK = 10;
  localparam int unsigned SFS_F_WDOG = 9;
  localparam int unsigned SFS_F_OVERTEMP_SHUTDOWN = 8;
  localparam int unsigned SFS_F_REGUV = 6;
  localparam int unsigned SFS_F_LSUV = 4;
  localparam int unsigned SFS_F_PUMPUV = 2;
  localparam int unsigned SFS_F_PUMPABS = 1;
  localparam int unsigned SFS_F_PUMPREL = 0;
  // control fields
  localparam int unsigned SFS_C_LOCKDIS = 9;
  localparam int unsigned SFS_C_WDI_LO = 5;
  localparam int unsigned SFS_C_WDEN = 3;
  localparam int unsigned SFS_C_CLR = 1;
  // regulator fields
  localparam int unsigned SFS_R_MONDIS = 2;
  localparam int unsigned SFS_R_THR_LO = 0;
  // reset values
  localparam logic [SFS_DW-1:0] SFS_CTRL_RST = 11'h000;
  localparam logic [SFS_DW-1:0] SFS_REG_RST = 11'h000;
  // timing
  localparam int unsigned SFS_CLK_NS = 20;
  localparam int unsigned SFS_PG_LOW_NS = 56000;
  localparam int unsigned SFS_PG_LOW_CYC = (SFS_PG_LOW_NS + SFS_CLK_NS - 1) / SFS_CLK_NS;
  localparam int unsigned SFS_GATE_LOW_NS = 1000;
  localparam int unsigned SFS_GATE_LOW_CYC = (SFS_GATE_LOW_NS + SFS_CLK_NS - 1) / SFS_CLK_NS;
  localparam int unsigned SFS_MS_NS = 1000000;
  localparam int unsigned SFS_WD_MS_CYC = SFS_MS_NS / SFS_CLK_NS;
  // watchdog intervals in milliseconds
  localparam logic [6:0] SFS_WD_MS0 = 7'h0a;
  localparam logic [6:0] SFS_WD_MS1 = 7'h14;
  localparam logic [6:0] SFS_WD_MS2 = 7'h32;
  localparam logic [6:0] SFS_WD_MS3 = 7'h64;

  // interval select to milliseconds
  function automatic logic [6:0] sfs_wd_ms(input logic [1:0] sel);
    unique case (sel)
      2'h0: sfs_wd_ms = SFS_WD_MS0;
      2'h1: sfs_wd_ms = SFS_WD_MS1;
      2'h2: sfs_wd_ms = SFS_WD_MS2;
      2'h3: sfs_wd_ms = SFS_WD_MS3;
    endcase
  endfunction
endpackage

// ---- include/sfs_wd_if.sv ----
`timescale 1ns/1ps
interface sfs_wd_if;
  logic       wd_enable;
  logic [1:0] wd_interval;
  logic       wd_kick;
  logic       wd_expire;
  logic       reg_under;
  logic       pg_low;
  // supervisor side
  modport core (output wd_enable, output wd_interval, output wd_kick,
                output reg_under, input wd_expire, input pg_low);
  // timer side
  modport wdog (input wd_enable, input wd_interval, input wd_kick,
                input reg_under, output wd_expire, output pg_low);
endinterface
